// file: common/asoq_map.svh
// offsets, field positions, reset values and timing counts of the scan and output queue block
// assumes a 20 MHz board clock and byte addressing on the local register port
`ifndef ASOQ_MAP_SVH
`define ASOQ_MAP_SVH
// =============================================
// register offsets
`define ASOQ_ADDR_BCW 8'h00
`define ASOQ_ADDR_SCAN 8'h10
`define ASOQ_ADDR_OQ 8'h18
`define ASOQ_ADDR_OQC 8'h1c
// =============================================
// reset values
`define ASOQ_BCW_RESET 32'h00000040
`define ASOQ_SCAN_RESET 32'h00000000
`define ASOQ_OQC_RESET 32'h00007ffe
// =============================================
// board control word fields
`define ASOQ_BCW_AIM 2:0
`define ASOQ_BCW_ISYNC 4
`define ASOQ_BCW_OBIN 6
`define ASOQ_BCW_SIMUL 7
`define ASOQ_BCW_THR_RISE 8
// =============================================
// scan and sync fields
`define ASOQ_SCAN_SIZE 1:0
`define ASOQ_SCAN_TWO 2
`define ASOQ_SCAN_SINGLE 3
`define ASOQ_SCAN_SRC 5:4
`define ASOQ_SCAN_CHSEL 12:8
// =============================================
// output queue word and control fields
`define ASOQ_OQ_DATA 15:0
`define ASOQ_OQ_TAG 17:16
`define ASOQ_OQ_GEND 18
`define ASOQ_OQ_BEND 19
`define ASOQ_OQC_THR 14:0
`define ASOQ_OQC_CLR 15
`define ASOQ_OQC_FLAG 16
// =============================================
// input modes and depths
`define ASOQ_AIM_DIFF 3'h0
`define ASOQ_OQ_DEPTH 32768
`define ASOQ_XF_DEPTH 256
`define ASOQ_IN_DEPTH 32
// =============================================
// timing
`define ASOQ_CLK_HZ 20000000
`define ASOQ_CONV_RATE_HZ 300000
`define ASOQ_CONV_CYCLES (`ASOQ_CLK_HZ / `ASOQ_CONV_RATE_HZ)
`endif

// file: common/asoq_pkg.sv
// types shared by the scan and output queue block
// assumes asoq_map.svh is included by the files that need widths
package asoq_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WAIT, ST_PUSH} asoq_scan_st_t;
	typedef enum logic [1:0] {SRC_GEN_A, SRC_GEN_B, SRC_EXT, SRC_SOFT} asoq_src_t;
	typedef struct packed {
		logic [2:0] bcw_aim;
		logic bcw_isync;
		logic bcw_obin;
		logic bcw_simul;
		logic bcw_thr_rise;
		logic [1:0] ss_size;
		logic ss_two;
		logic ss_single;
		asoq_src_t ss_src;
		logic [4:0] ss_chsel;
		logic [14:0] thr;
		logic oq_clr;
		logic thr_flag;
		logic thr_event;
		logic [31:0] rdata;
		logic rvalid;
		logic ext_q;
		asoq_scan_st_t st;
		logic [4:0] idx;
		logic [5:0] left;
		logic [6:0] pace;
		logic adc_start;
		logic [4:0] adc_chan;
		logic [2:0] adc_src;
		logic [16:0] samp;
		logic [63:0] dac_data;
		logic [3:0] dac_load;
		logic [63:0] stage;
		logic [3:0] smask;
		logic grp_rdy;
		logic burst_done;
	} asoq_top_st_t;
endpackage

// file: design/asoq_top.sv
// scan sequencer, output sample queue and register port of the analog i/o block
// assumes one clock, inputs synchronous to it, converters handshake by start/done pulses
`include "asoq_map.svh"

// =============================================
// fifo with registered show-ahead output
module asoq_fifo #(parameter int WIDTH = 20, parameter int DEPTH = 32,
	parameter int AW = $clog2(DEPTH)) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	output logic [AW:0] level
);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic ov;
		logic [WIDTH-1:0] od;
	} asoq_fifo_st_t;
	asoq_fifo_st_t s, next_s;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, load;
	assign in_ready = (s.cnt != (AW+1)'(DEPTH)) && !clr;
	assign push = in_valid && in_ready;
	assign load = (s.cnt != '0) && (!s.ov || out_ready);
	assign out_valid = s.ov;
	assign out_data = s.od;
	assign level = s.cnt + (AW+1)'(s.ov);
	always_ff @(posedge clk) begin
		if (push) begin
			mem[s.wp] <= in_data;
		end
	end
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.wp = s.wp + 1'b1;
		end
		if (load) begin
			next_s.od = mem[s.rp];
			next_s.ov = 1'b1;
			next_s.rp = s.rp + 1'b1;
		end else if (out_ready) begin
			next_s.ov = 1'b0;
		end
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(load);
		if (clr) begin
			next_s = '0;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

module asoq_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic rate_a_tick,
	input wire logic rate_b_tick,
	input wire logic ext_sync,
	output logic adc_start,
	output logic [4:0] adc_chan,
	output logic [2:0] adc_src,
	input wire logic [15:0] adc_data,
	input wire logic adc_done,
	output logic in_valid,
	input wire logic in_ready,
	output logic [16:0] in_data,
	input wire logic out_clk_tick,
	output logic [63:0] dac_data,
	output logic [3:0] dac_load,
	output logic burst_done,
	output logic thr_event
);
	asoq_pkg::asoq_top_st_t s, next_s;
	logic trig, done, oq_push, oq_ready, oq_v, xf_ready, xf_v, xf_rdy, xin_ready;
	logic [19:0] oq_d, xf_d;
	logic [15:0] oq_level, oval;
	logic [5:0] nchan;
	logic [4:0] chan;
	logic [1:0] tag;
	logic [7:0] gap;
	// =============================================
	// data path buffers
	assign oq_push = reg_wr && reg_addr == `ASOQ_ADDR_OQ;
	asoq_fifo #(.WIDTH(20), .DEPTH(`ASOQ_OQ_DEPTH)) u_oq (
		.clk(clk), .rst(rst), .clr(s.oq_clr),
		.in_valid(oq_push), .in_ready(oq_ready), .in_data(reg_wdata[19:0]),
		.out_valid(oq_v), .out_data(oq_d), .out_ready(xf_rdy), .level(oq_level)
	);
	// transfer stage: queued samples here are not counted by the threshold
	asoq_fifo #(.WIDTH(20), .DEPTH(`ASOQ_XF_DEPTH)) u_xf (
		.clk(clk), .rst(rst), .clr(s.oq_clr),
		.in_valid(oq_v), .in_ready(xf_rdy), .in_data(oq_d),
		.out_valid(xf_v), .out_data(xf_d), .out_ready(xf_ready), .level()
	);
	// scan results; a full buffer stalls the sequencer instead of losing samples
	asoq_fifo #(.WIDTH(17), .DEPTH(`ASOQ_IN_DEPTH)) u_in (
		.clk(clk), .rst(rst), .clr(1'b0),
		.in_valid(s.st == asoq_pkg::ST_PUSH), .in_ready(xin_ready), .in_data(s.samp),
		.out_valid(in_valid), .out_data(in_data), .out_ready(in_ready), .level()
	);

	// =============================================
	// scan decode
	always_comb begin
		unique case (s.ss_src)
			asoq_pkg::SRC_GEN_A: trig = rate_a_tick;
			asoq_pkg::SRC_GEN_B: trig = rate_b_tick;
			asoq_pkg::SRC_EXT: trig = s.ext_q && !ext_sync;
			asoq_pkg::SRC_SOFT: trig = s.bcw_isync;
		endcase
		if (s.ss_two) begin
			nchan = 6'h02;
			chan = s.idx;
		end else if (s.ss_single) begin
			nchan = 6'h01;
			chan = s.ss_chsel;
		end else if (s.bcw_aim == `ASOQ_AIM_DIFF) begin
			// only sixteen pairs exist, so the 32 size clamps to all of them
			nchan = (s.ss_size == 2'h3) ? 6'h10 : 6'(6'h04 << s.ss_size);
			chan = {s.idx[3:0], 1'b0};
		end else begin
			nchan = 6'(6'h04 << s.ss_size);
			chan = s.idx;
		end
	end
	assign done = s.st == asoq_pkg::ST_PUSH && xin_ready && s.left == 6'h01;
	// =============================================
	// output staging
	assign tag = xf_d[`ASOQ_OQ_TAG];
	assign oval = xf_d[`ASOQ_OQ_DATA] ^ {!s.bcw_obin, 15'h0000};
	assign xf_ready = s.bcw_simul ? !s.grp_rdy : out_clk_tick;
	always_comb begin
		next_s = s;
		next_s.rvalid = reg_rd;
		next_s.adc_start = 1'b0;
		next_s.dac_load = 4'h0;
		next_s.burst_done = 1'b0;
		next_s.ext_q = ext_sync;
		next_s.oq_clr = 1'b0;
		if (s.pace != 7'h00) begin
			next_s.pace = s.pace - 7'h01;
		end
		// register writes
		if (reg_wr && reg_addr == `ASOQ_ADDR_BCW) begin
			next_s.bcw_aim = reg_wdata[`ASOQ_BCW_AIM];
			next_s.bcw_obin = reg_wdata[`ASOQ_BCW_OBIN];
			next_s.bcw_simul = reg_wdata[`ASOQ_BCW_SIMUL];
			next_s.bcw_thr_rise = reg_wdata[`ASOQ_BCW_THR_RISE];
		end
		if (reg_wr && reg_addr == `ASOQ_ADDR_SCAN) begin
			next_s.ss_size = reg_wdata[`ASOQ_SCAN_SIZE];
			next_s.ss_two = reg_wdata[`ASOQ_SCAN_TWO];
			next_s.ss_single = reg_wdata[`ASOQ_SCAN_SINGLE];
			next_s.ss_src = asoq_pkg::asoq_src_t'(reg_wdata[`ASOQ_SCAN_SRC]);
			next_s.ss_chsel = reg_wdata[`ASOQ_SCAN_CHSEL];
		end
		if (reg_wr && reg_addr == `ASOQ_ADDR_OQC) begin
			next_s.thr = reg_wdata[`ASOQ_OQC_THR];
			next_s.oq_clr = reg_wdata[`ASOQ_OQC_CLR];
		end
		// software sync drops at scan end, but a fresh set in that cycle wins
		if (done) begin
			next_s.bcw_isync = 1'b0;
		end
		if (reg_wr && reg_addr == `ASOQ_ADDR_BCW) begin
			next_s.bcw_isync = reg_wdata[`ASOQ_BCW_ISYNC] | (s.bcw_isync & !done);
		end
		// register reads
		unique case (reg_addr)
			`ASOQ_ADDR_BCW: next_s.rdata = {23'h000000, s.bcw_thr_rise, s.bcw_simul, s.bcw_obin,
				1'b0, s.bcw_isync, 1'b0, s.bcw_aim};
			`ASOQ_ADDR_SCAN: next_s.rdata = {19'h00000, s.ss_chsel, 2'h0, s.ss_src, s.ss_single,
				s.ss_two, s.ss_size};
			`ASOQ_ADDR_OQC: next_s.rdata = {15'h0000, s.thr_flag, s.oq_clr, s.thr};
			default: next_s.rdata = 32'h00000000;
		endcase
		// threshold flag counts the queue only
		next_s.thr_flag = oq_level > {1'b0, s.thr};
		next_s.thr_event = s.bcw_thr_rise ? (next_s.thr_flag && !s.thr_flag) :
			(!next_s.thr_flag && s.thr_flag);
		// scan sequencer; triggers while busy fall through unused
		unique case (s.st)
			asoq_pkg::ST_IDLE: begin
				if (trig) begin
					next_s.st = asoq_pkg::ST_CONV;
					next_s.idx = 5'h00;
					next_s.left = nchan;
				end
			end
			asoq_pkg::ST_CONV: begin
				if (s.pace == 7'h00) begin
					next_s.pace = 7'(`ASOQ_CONV_CYCLES - 1);
					next_s.adc_start = 1'b1;
					next_s.adc_chan = chan;
					next_s.adc_src = s.bcw_aim;
					next_s.st = asoq_pkg::ST_WAIT;
				end
			end
			asoq_pkg::ST_WAIT: begin
				// zero and reference tests return whatever code the converter measures
				if (adc_done) begin
					next_s.samp = {s.adc_chan == 5'h00, adc_data ^ {!s.bcw_obin, 15'h0000}};
					next_s.st = asoq_pkg::ST_PUSH;
				end
			end
			asoq_pkg::ST_PUSH: begin
				if (xin_ready) begin
					next_s.idx = s.idx + 5'h01;
					next_s.left = s.left - 6'h01;
					next_s.st = (s.left == 6'h01) ? asoq_pkg::ST_IDLE : asoq_pkg::ST_CONV;
				end
			end
		endcase
		// output clocking
		if (xf_v && xf_ready) begin
			next_s.burst_done = xf_d[`ASOQ_OQ_BEND];
			if (s.bcw_simul) begin
				next_s.stage[{tag, 4'h0} +: 16] = oval;
				next_s.smask[tag] = 1'b1;
				next_s.grp_rdy = xf_d[`ASOQ_OQ_GEND];
			end else begin
				next_s.dac_data[{tag, 4'h0} +: 16] = oval;
				next_s.dac_load = 4'(4'h1 << tag);
			end
		end
		if (s.bcw_simul && s.grp_rdy && out_clk_tick) begin
			for (int i = 0; i < 4; i++) begin
				if (s.smask[i]) begin
					next_s.dac_data[i*16 +: 16] = s.stage[i*16 +: 16];
				end
			end
			next_s.dac_load = s.smask;
			next_s.smask = 4'h0;
			next_s.grp_rdy = 1'b0;
		end
		if (s.oq_clr) begin
			next_s.smask = 4'h0;
			next_s.grp_rdy = 1'b0;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.bcw_obin <= 1'b1;
			s.thr <= 15'h7ffe;
			s.pace <= 7'h00;
			// idle level of the sync pin, so a fall right after reset is not lost
			s.ext_q <= 1'b1;
		end else begin
			s <= next_s;
		end
	end
	assign reg_rdata = s.rdata;
	assign reg_rvalid = s.rvalid;
	assign adc_start = s.adc_start;
	assign adc_chan = s.adc_chan;
	assign adc_src = s.adc_src;
	assign dac_data = s.dac_data;
	assign dac_load = s.dac_load;
	assign burst_done = s.burst_done;
	assign thr_event = s.thr_event;
	// =============================================
	// checks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap <= 8'hff;
		end else if (s.adc_start) begin
			gap <= 8'h00;
		end else if (gap != 8'hff) begin
			gap <= gap + 8'h01;
		end
	end
	sequence idle_trig;
		s.st == asoq_pkg::ST_IDLE && trig;
	endsequence
	sequence clr_done;
		!s.oq_clr && oq_level == 16'h0000;
	endsequence
	chk_reset_diff_mode: assert property (@(posedge clk) $fell(rst) |->
		s.bcw_aim == 3'h0 && s.bcw_obin && s.thr == 15'h7ffe)
		else $error("defaults wrong after reset");
	chk_diff_even_chan: assert property (@(posedge clk) disable iff (rst)
		adc_start && s.bcw_aim == 3'h0 && !s.ss_two && !s.ss_single |-> !adc_chan[0])
		else $error("odd channel in differential mode");
	chk_src_follows_mode: assert property (@(posedge clk) disable iff (rst)
		adc_start |-> adc_src == s.bcw_aim)
		else $error("converter source not input mode");
	chk_scan_from_zero: assert property (@(posedge clk) disable iff (rst)
		idle_trig |=> s.idx == 5'h00 && s.left == $past(nchan) && s.st == asoq_pkg::ST_CONV)
		else $error("scan did not start at channel zero");
	chk_conv_spacing: assert property (@(posedge clk) disable iff (rst)
		adc_start |-> gap >= 8'(`ASOQ_CONV_CYCLES - 1))
		else $error("conversions too close");
	chk_busy_ignores: assert property (@(posedge clk) disable iff (rst)
		s.st == asoq_pkg::ST_WAIT && trig && !adc_done |=> s.st == asoq_pkg::ST_WAIT)
		else $error("trigger disturbed running scan");
	chk_ext_fall: assert property (@(posedge clk) disable iff (rst)
		s.ss_src == asoq_pkg::SRC_EXT && s.st == asoq_pkg::ST_IDLE && $fell(ext_sync)
		|=> s.st == asoq_pkg::ST_CONV)
		else $error("falling sync edge missed");
	chk_soft_hold: assert property (@(posedge clk) disable iff (rst)
		s.ss_src == asoq_pkg::SRC_SOFT && s.st != asoq_pkg::ST_IDLE && s.bcw_isync && !done
		|=> s.bcw_isync)
		else $error("sync bit dropped during scan");
	chk_two_chan: assert property (@(posedge clk) disable iff (rst)
		idle_trig and s.ss_two |=> s.left == 6'h02)
		else $error("two-channel mode not honoured");
	chk_single_chan: assert property (@(posedge clk) disable iff (rst)
		idle_trig and !s.ss_two && s.ss_single |=> s.left == 6'h01)
		else $error("single mode converts more than one");
	chk_queue_read_zero: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == `ASOQ_ADDR_OQ |=> reg_rvalid && reg_rdata == 32'h00000000)
		else $error("queue read not zero");
	chk_clear_empties: assert property (@(posedge clk) disable iff (rst)
		s.oq_clr |=> clr_done)
		else $error("clear did not empty queue");
	chk_thr_flag: assert property (@(posedge clk) disable iff (rst)
		oq_level > {1'b0, s.thr} ##1 oq_level > {1'b0, s.thr} |-> s.thr_flag)
		else $error("threshold flag low above threshold");
	chk_thr_edge: assert property (@(posedge clk) disable iff (rst)
		thr_event |-> s.thr_flag == s.bcw_thr_rise && $past(s.thr_flag) != s.thr_flag)
		else $error("threshold event without edge");
	chk_seq_one_load: assert property (@(posedge clk) disable iff (rst)
		dac_load != 4'h0 && !$past(s.bcw_simul) |-> $onehot(dac_load))
		else $error("sequential mode loaded several channels");
endmodule

// file: tb/analog_scan_and_output_queue_bench.sv
// self-checking bench for the scan sequencer and output sample queue
// assumes asoq_map.svh offsets and the converter model beside the block
`include "asoq_map.svh"
module analog_scan_and_output_queue_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ext_sync = 1'b1;
	logic rate_a_tick = 1'b0, rate_b_tick = 1'b0, in_ready = 1'b0, out_clk_tick = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'h38bc, rs = 32'h38bc;
	logic reg_rvalid, adc_start, adc_done, in_valid, burst_done, thr_event, hold = 1'b0;
	logic [4:0] adc_chan;
	logic [2:0] adc_src;
	logic [15:0] adc_data;
	logic [16:0] in_data;
	logic [63:0] dac_data;
	logic [3:0] dac_load, last_load;
	logic [16:0] got[$];
	logic [7:0] starts[$];
	int n_mismatch = 0, checks = 0, gap = 0, n_load = 0, n_burst = 0, n_thr = 0, i;
	asoq_top dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.rate_a_tick(rate_a_tick), .rate_b_tick(rate_b_tick), .ext_sync(ext_sync),
		.adc_start(adc_start), .adc_chan(adc_chan), .adc_src(adc_src), .adc_data(adc_data),
		.adc_done(adc_done), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
		.out_clk_tick(out_clk_tick), .dac_data(dac_data), .dac_load(dac_load),
		.burst_done(burst_done), .thr_event(thr_event));
	asoq_conv_model conv (.clk(clk), .rst(rst), .adc_start(adc_start), .adc_chan(adc_chan),
		.adc_src(adc_src), .adc_data(adc_data), .adc_done(adc_done));
	initial begin
		forever #25 clk = ~clk;
	end
	// =============================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int n_of(input logic [12:0] sc, input logic se);
		if (sc[2]) return 2;
		if (sc[3]) return 1;
		if (!se && sc[1:0] == 2'h3) return 16;
		return 4 << sc[1:0];
	endfunction
	function automatic logic [4:0] ch_of(input logic [12:0] sc, input logic se, input int k);
		if (sc[2]) return 5'(k);
		if (sc[3]) return sc[12:8];
		return se ? 5'(k) : 5'(2 * k);
	endfunction
	task automatic tally_and_finish();
		if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rvalid, 1'b1);
		d = reg_rdata;
	endtask
	task automatic tick(input int w);
		@(posedge clk);
		if (w == 0) rate_a_tick <= 1'b1;
		else if (w == 1) rate_b_tick <= 1'b1;
		else out_clk_tick <= 1'b1;
		@(posedge clk);
		rate_a_tick <= 1'b0;
		rate_b_tick <= 1'b0;
		out_clk_tick <= 1'b0;
	endtask
	task automatic fire(input logic [1:0] s, input logic [31:0] bcw);
		case (s)
			2'h0: tick(0);
			2'h1: tick(1);
			2'h2: begin
				@(posedge clk);
				ext_sync <= 1'b0;
				@(posedge clk);
				ext_sync <= 1'b1;
			end
			default: wr(`ASOQ_ADDR_BCW, bcw | 32'h10);
		endcase
	endtask
	// =============================================
	// monitors: sample and start capture, pacing, output loads, random stall
	always @(posedge clk) begin
		rs = lfsr(rs);
		if (in_valid === 1'b1 && in_ready === 1'b1) got.push_back(in_data);
		if (adc_start === 1'b1) begin
			// 66-cycle spacing leaves 65 idle edges between two starts
			if (starts.size() > 0) chk(gap >= 65, 1'b1);
			starts.push_back({adc_src, adc_chan});
			gap = 0;
		end else begin
			gap++;
		end
		if (dac_load !== 4'h0) begin
			n_load++;
			last_load = dac_load;
		end
		if (burst_done === 1'b1) n_burst++;
		if (thr_event === 1'b1) n_thr++;
		in_ready <= !hold && rs[2];
	end
	// =============================================
	// one scan: configure, trigger, retrigger while busy unless the source is software sync, compare samples
	task automatic scan(input logic [12:0] sc, input logic [2:0] aim, input logic obin,
		input logic stall);
		int n, k;
		logic [4:0] ch;
		logic [15:0] ed;
		logic [31:0] r, bcw;
		n = n_of(sc, aim == 3'h1);
		bcw = 32'(aim) | (obin ? 32'h40 : 32'h0);
		got.delete();
		starts.delete();
		hold = stall;
		wr(`ASOQ_ADDR_SCAN, 32'(sc));
		wr(`ASOQ_ADDR_BCW, bcw);
		fire(sc[5:4], bcw);
		if (sc[5:4] == 2'h3 && n > 1) begin
			rd(`ASOQ_ADDR_BCW, r);
			chk(r[4], 1'b1);
		end
		repeat (20) @(posedge clk);
		if (sc[5:4] != 2'h3) fire(sc[5:4], bcw);
		if (stall) begin
			repeat (n * 120) @(posedge clk);
			chk(got.size(), 0);
			hold = 1'b0;
		end
		for (k = 0; k < 20000 && got.size() < n; k++) @(posedge clk);
		if (k == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
		repeat (300) @(posedge clk);
		chk(got.size(), n);
		for (k = 0; k < n && k < got.size(); k++) begin
			ch = ch_of(sc, aim == 3'h1, k);
			ed = (aim == 3'h2) ? 16'h8000 : {aim, ch, 8'ha5};
			ed[15] = ed[15] ^ !obin;
			chk(starts[k][7:5], aim);
			if (aim == 3'h2) chk(got[k][15:0], ed);
			else chk(got[k], {ch == 5'h0, ed});
		end
		if (sc[5:4] == 2'h3) begin
			rd(`ASOQ_ADDR_BCW, r);
			chk(r[4], 1'b0);
		end
	endtask
	// =============================================
	// sequential output words with random value, tag and ignored bits
	task automatic oq_seq(input logic obin);
		logic [15:0] d;
		logic [1:0] t;
		int k, nl, nb;
		wr(`ASOQ_ADDR_BCW, obin ? 32'h40 : 32'h0);
		for (k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			d = seed[15:0];
			t = seed[17:16];
			nl = n_load;
			nb = n_burst;
			wr(`ASOQ_ADDR_OQ, {seed[31:20], k == 5, 1'b0, t, d});
			repeat (8) @(posedge clk);
			tick(2);
			repeat (2) @(posedge clk);
			#1;
			chk(64'(n_load - nl), 1);
			chk(last_load, 4'h1 << t);
			chk((dac_data >> (16 * int'(t))) & 64'hffff, d ^ {!obin, 15'h0});
			chk(64'(n_burst - nb), k == 5);
		end
	endtask
	// =============================================
	// main sequence
	initial begin
		logic [31:0] r;
		int nl;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(`ASOQ_ADDR_BCW, r);
		chk(r, 32'h40);
		rd(`ASOQ_ADDR_SCAN, r);
		chk(r, 32'h0);
		rd(`ASOQ_ADDR_OQC, r);
		chk(r, 32'h7ffe);
		rd(`ASOQ_ADDR_OQ, r);
		chk(r, 32'h0);
		wr(8'h04, 32'hffffffff);
		rd(8'h04, r);
		chk(r, 32'h0);
		rd(`ASOQ_ADDR_BCW, r);
		chk(r, 32'h40);
		// corners: 32 samples held in the input fifo, clamp, two-channel, single, zero test
		scan(13'h0033, 3'h1, 1'b1, 1'b1);
		scan(13'h0023, 3'h0, 1'b1, 1'b0);
		scan(13'h0004, 3'h1, 1'b0, 1'b0);
		scan(13'h1d18, 3'h0, 1'b1, 1'b0);
		scan(13'h0030, 3'h2, 1'b0, 1'b0);
		for (i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			scan({seed[12:8], 2'h0, seed[5:4], 2'h0, seed[1:0]}, {2'h0, seed[16]}, seed[17], 1'b0);
		end
		oq_seq(1'b1);
		oq_seq(1'b0);
		wr(`ASOQ_ADDR_BCW, 32'hc0);
		for (i = 0; i < 4; i++) begin
			wr(`ASOQ_ADDR_OQ, {12'h0, 1'b0, i == 3, 2'(i), 16'(i * 16'h1111 + 16'h0f0f)});
		end
		repeat (10) @(posedge clk);
		tick(2);
		repeat (2) @(posedge clk);
		#1;
		chk(last_load, 4'hf);
		chk(dac_data, 64'h4242313120200f0f);
		// more words than the transfer fifo holds, so the queue level rises
		wr(`ASOQ_ADDR_BCW, 32'h40);
		wr(`ASOQ_ADDR_OQC, 32'h2);
		for (i = 0; i < 270; i++) wr(`ASOQ_ADDR_OQ, 32'(i));
		repeat (4) @(posedge clk);
		rd(`ASOQ_ADDR_OQC, r);
		chk(r, 32'h00010002);
		rd(`ASOQ_ADDR_OQ, r);
		chk(r, 32'h0);
		// flag falls with the falling edge selected: exactly one event
		nl = n_thr;
		wr(`ASOQ_ADDR_OQC, 32'h7ffe);
		repeat (3) @(posedge clk);
		rd(`ASOQ_ADDR_OQC, r);
		chk(r, 32'h7ffe);
		chk(64'(n_thr - nl), 1);
		wr(`ASOQ_ADDR_OQC, 32'hfffe);
		rd(`ASOQ_ADDR_OQC, r);
		chk(r, 32'h7ffe);
		nl = n_load;
		tick(2);
		repeat (3) @(posedge clk);
		chk(64'(n_load - nl), 0);
		tally_and_finish();
	end
endmodule

// file: tb/asoq_conv_model.sv
// converter stand-in: answers every conversion start with one done pulse
// assumes start, channel and mode arrive registered on the board clock
module asoq_conv_model #(
	parameter int SLOW = 40
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic adc_start,
	input wire logic [4:0] adc_chan,
	input wire logic [2:0] adc_src,
	output logic [15:0] adc_data,
	output logic adc_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] cnt;
	logic busy;
	logic [15:0] res;
	logic [15:0] noise;
	// =============================================
	// conversion timing
	// odd channels answer slowly, so pacing and slow answers both occur
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 8'h00;
			busy <= 1'b0;
			res <= 16'h0000;
			noise <= 16'h0000;
			adc_done <= 1'b0;
		end else begin
			noise <= noise + 16'h1357;
			adc_done <= 1'b0;
			if (adc_start) begin
				busy <= 1'b1;
				cnt <= adc_chan[0] ? 8'(SLOW) : 8'h02;
				res <= (adc_src == 3'h2) ? 16'h8000 : {adc_src, adc_chan, 8'ha5};
			end else if (busy) begin
				if (cnt == 8'h00) begin
					busy <= 1'b0;
					adc_done <= 1'b1;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
		end
	end
	// result lines carry junk outside the done cycle
	assign adc_data = adc_done ? res : ~noise;
endmodule
